//--- src/qdw_pkg.sv
// Purpose: constants for the quad DAC serial write port
// Assumes: 16-bit frames, MSB first, link clock is the serial clock
// Notes: no software-visible registers
package qdw_pkg;
	localparam int unsigned QDW_WORD_W = 16;
	localparam int unsigned QDW_CNT_W = 5;
	localparam logic [4:0] QDW_LAST_BIT = 5'h10;
	localparam logic [15:0] QDW_WORD_RST = 16'h0000;
	localparam int unsigned QDW_SCLK_MAX_MHZ = 30;
	localparam int unsigned QDW_CORE_MHZ = 10;
	localparam int unsigned QDW_BUF_DEPTH = 2;
	typedef enum logic [1:0] {
		QDW_IDLE = 2'b00,
		QDW_SHIFT = 2'b01,
		QDW_DONE = 2'b10
	} qdw_state_e;
endpackage

//--- src/qdw_buf2.sv
// Purpose: two-entry valid/ready buffer for captured words
// Assumes: single clock domain
// Notes: full and empty are exact
`timescale 1ns/1ps
module qdw_buf2 (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [qdw_pkg::QDW_WORD_W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [qdw_pkg::QDW_WORD_W-1:0] out_data_o
);
	import qdw_pkg::*;
	logic [QDW_WORD_W-1:0] mem_q [QDW_BUF_DEPTH];
	logic rd_q, wr_q;
	logic [1:0] cnt_q;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	assign in_ready_o = (cnt_q != 2'h2);
	assign out_valid_o = (cnt_q != 2'h0);
	assign out_data_o = mem_q[rd_q];
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			cnt_q <= 2'h0;
			mem_q[0] <= QDW_WORD_RST;
			mem_q[1] <= QDW_WORD_RST;
		end else begin
			if (push) begin
				mem_q[wr_q] <= in_data_i;
				wr_q <= ~wr_q;
			end
			if (pop) begin
				rd_q <= ~rd_q;
			end
			cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
		end
	end
endmodule // qdw_buf2

//--- src/qdw_serial_port.sv
// Purpose: write-only three-wire serial input port, device side
// Assumes: host keeps serial clock within limit; frame pin is async to sclk
// Notes: word crosses to core by toggle handshake plus hold register
`timescale 1ns/1ps
module qdw_serial_port (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic sclk_i,
	input wire logic frame_n_i,
	input wire logic sdata_i,
	output logic word_valid_o,
	input wire logic word_ready_i,
	output logic [qdw_pkg::QDW_WORD_W-1:0] word_data_o,
	output logic in_buf_pd_o,
	output logic frame_active_o,
	output logic abort_o,
	output logic overrun_o
);
	import qdw_pkg::*;

	// Core reset release
	logic rst_s1_q, rst_s2_q;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s2_q | rst_s1_q;
		end
	end
	wire core_rst_n = rst_s2_q;

	// Link side: frame high clears the shift logic asynchronously, so no
	// sclk edge is needed after the frame ends.
	wire link_rst_n = rst_n_i & ~frame_n_i;
	logic [QDW_WORD_W-1:0] shift_q;
	logic [QDW_CNT_W-1:0] bits_q;
	logic [QDW_WORD_W-1:0] hold_q;
	logic done_tgl_q;
	logic full_q;
	// One compare function, with limits 16 and 15, serves the shift enable and the capture strobe
	function automatic logic cnt_is(input logic [QDW_CNT_W-1:0] cnt,
		input logic [QDW_CNT_W-1:0] lim);
		return (cnt == lim);
	endfunction
	wire last_edge = cnt_is(bits_q, QDW_LAST_BIT - 5'h01);
	wire shifting = !cnt_is(bits_q, QDW_LAST_BIT);

	always_ff @(negedge sclk_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			shift_q <= QDW_WORD_RST;
			bits_q <= '0;
		end else if (shifting) begin
			shift_q <= {shift_q[QDW_WORD_W-2:0], sdata_i};
			bits_q <= 5'(bits_q + 5'h01);
		end
	end

	// Word-complete flag as a single flop, so the core never samples a
	// multi-bit counter compare that can glitch on the 15 to 16 carry
	always_ff @(negedge sclk_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			full_q <= 1'b0;
		end else if (last_edge) begin
			full_q <= 1'b1;
		end
	end

	// Hold register and toggle survive frame end; only chip reset clears them
	always_ff @(negedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_q <= QDW_WORD_RST;
			done_tgl_q <= 1'b0;
		end else if (!frame_n_i && shifting && last_edge) begin
			hold_q <= {shift_q[QDW_WORD_W-2:0], sdata_i};
			done_tgl_q <= ~done_tgl_q;
		end
	end

	// Core side synchronisers
	logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
	logic frm_s1_q, frm_s2_q, frm_s3_q;
	logic cnt_done_s1_q, cnt_done_s2_q;
	always_ff @(posedge core_clk_i or negedge core_rst_n) begin
		if (!core_rst_n) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
			frm_s1_q <= 1'b1;
			frm_s2_q <= 1'b1;
			frm_s3_q <= 1'b1;
			cnt_done_s1_q <= 1'b0;
			cnt_done_s2_q <= 1'b0;
		end else begin
			tgl_s1_q <= done_tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
			frm_s1_q <= frame_n_i;
			frm_s2_q <= frm_s1_q;
			frm_s3_q <= frm_s2_q;
			cnt_done_s1_q <= full_q;
			cnt_done_s2_q <= cnt_done_s1_q;
		end
	end
	wire word_evt = tgl_s2_q ^ tgl_s3_q;
	wire frame_fall = frm_s3_q & ~frm_s2_q;
	wire frame_rise = ~frm_s3_q & frm_s2_q;

	// Frame tracking state machine in core domain
	qdw_state_e st_q, st_d;
	logic got_word_q, got_word_d;
	always_comb begin
		st_d = st_q;
		got_word_d = got_word_q;
		case (st_q)
			QDW_IDLE: begin
				if (frame_fall) begin
					st_d = QDW_SHIFT;
					got_word_d = 1'b0;
				end
			end
			QDW_SHIFT: begin
				if (word_evt) begin
					// A rise in the same cycle must not strand the machine in done
					st_d = frame_rise ? QDW_IDLE : QDW_DONE;
					got_word_d = 1'b1;
				end else if (frame_rise) begin
					st_d = QDW_IDLE;
				end
			end
			QDW_DONE: begin
				if (frame_rise) begin
					st_d = QDW_IDLE;
				end
			end
			default: begin
				st_d = QDW_IDLE;
			end
		endcase
	end

	// Abort: frame rose while still shifting and no word arrived
	logic abort_q, abort_d;
	assign abort_d = (st_q == QDW_SHIFT) && frame_rise && !word_evt;

	// Word into buffer; overflow flagged rather than blocking the host
	logic buf_in_ready;
	logic overrun_q;
	always_ff @(posedge core_clk_i or negedge core_rst_n) begin
		if (!core_rst_n) begin
			st_q <= QDW_IDLE;
			got_word_q <= 1'b0;
			abort_q <= 1'b0;
			overrun_q <= 1'b0;
		end else begin
			st_q <= st_d;
			got_word_q <= got_word_d;
			abort_q <= abort_d;
			overrun_q <= word_evt & ~buf_in_ready;
		end
	end

	// Hold is stable long before the toggle is seen two flops later
	qdw_buf2 u_buf (
		.clk_i(core_clk_i),
		.rst_n_i(core_rst_n),
		.in_valid_i(word_evt),
		.in_ready_o(buf_in_ready),
		.in_data_i(hold_q),
		.out_valid_o(word_valid_o),
		.out_ready_i(word_ready_i),
		.out_data_o(word_data_o)
	);

	// Buffers powered from frame fall until the sixteenth bit is in
	logic pd_q;
	always_ff @(posedge core_clk_i or negedge core_rst_n) begin
		if (!core_rst_n) begin
			pd_q <= 1'b1;
		end else if (frame_fall) begin
			pd_q <= 1'b0;
		end else if (cnt_done_s2_q || word_evt || got_word_q) begin
			pd_q <= 1'b1;
		end
	end

	assign in_buf_pd_o = pd_q;
	assign frame_active_o = (st_q != QDW_IDLE);
	assign abort_o = abort_q;
	assign overrun_o = overrun_q;
endmodule // qdw_serial_port

//--- testbench/qdw_serial_port_sva.sv
// Purpose: checker for the serial write port
// Assumes: core clock domain only
// Notes: bound to the top module
`timescale 1ns/1ps
module qdw_serial_port_sva (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic frame_n_i,
	input wire logic word_valid_o,
	input wire logic word_ready_i,
	input wire logic [15:0] word_data_o,
	input wire logic in_buf_pd_o,
	input wire logic frame_active_o,
	input wire logic abort_o,
	input wire logic overrun_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	frame_seen_a: assert property ($fell(frame_n_i) |-> ##[1:5] frame_active_o)
		else $error("frame not seen");
	buf_wake_a: assert property ($fell(frame_n_i) |-> ##[1:5] !in_buf_pd_o)
		else $error("buffers not woken");
	abort_idle_a: assert property (abort_o |-> frame_n_i && $past(frame_n_i))
		else $error("abort with frame low");
	abort_pulse_a: assert property (abort_o |=> !abort_o)
		else $error("abort too long");
	buf_sleep_a: assert property ($rose(word_valid_o) |-> ##[0:4] in_buf_pd_o)
		else $error("buffers left on");
	word_hold_a: assert property (word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_data_o))
		else $error("word dropped");
	lost_full_a: assert property (overrun_o |-> $past(word_valid_o))
		else $error("overrun while empty");
endmodule // qdw_serial_port_sva
bind qdw_serial_port qdw_serial_port_sva i_sva (.*);

//--- testbench/qdw_host_model.sv
// Purpose: host side serial master
// Assumes: clock idles high, still between frames
// Notes: 6 ns period set by the send task, above the host limit
`timescale 1ns/1ps
module qdw_host_model (
	output logic sclk_o,
	output logic frame_n_o,
	output logic sdata_o
);
	initial begin
		sclk_o = 1'b1;
		frame_n_o = 1'b1;
		sdata_o = 1'b0;
	end
	task automatic send(input logic [15:0] w, input int n);
		// Keep frame edges off the core clock edge
		#7;
		frame_n_o = 1'b0;
		#20;
		for (int i = 0; i < n; i++) begin
			sdata_o = (i < 16) ? w[15-i] : ~sdata_o;
			#3 sclk_o = 1'b0;
			#3 sclk_o = 1'b1;
		end
		#400 frame_n_o = 1'b1;
		sdata_o = ~sdata_o;
		// Long high time so the core sees every frame edge
		#400;
	endtask
endmodule // qdw_host_model

//--- testbench/qdw_serial_port_tb.sv
// Purpose: bench for the serial write port
// Assumes: host model drives the link
// Notes: pulses are counted, not sampled
`timescale 1ns/1ps
module qdw_serial_port_tb;
	logic clk;
	logic rst_n;
	logic rdy;
	logic sclk, frm_n, sd, valid, pd, abrt, ovr, act;
	logic [15:0] data;
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_ab = 0;
	int n_ov = 0;
	qdw_host_model i_host (.sclk_o(sclk), .frame_n_o(frm_n), .sdata_o(sd));
	qdw_serial_port i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk),
		.frame_n_i(frm_n), .sdata_i(sd), .word_valid_o(valid), .word_ready_i(rdy),
		.word_data_o(data), .in_buf_pd_o(pd), .frame_active_o(act), .abort_o(abrt),
		.overrun_o(ovr));
	task test_done;
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task take;
		for (int i = 0; i < 40 && valid !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk({15'h0, valid}, 16'h1);
		@(posedge clk) rdy <= 1'b1;
		@(posedge clk) rdy <= 1'b0;
		#1;
	endtask
	task t_word;
		i_host.send(16'hA5C3, 16);
		chk(data, 16'hA5C3);
		chk({15'h0, pd}, 16'h1);
		chk({15'h0, act}, 16'h0);
		take;
		chk({15'h0, valid}, 16'h0);
	endtask
	task t_abort;
		i_host.send(16'hFFFF, 8);
		repeat (4) @(posedge clk);
		chk(n_ab[15:0], 16'h1);
		chk({15'h0, valid}, 16'h0);
	endtask
	task t_extra;
		i_host.send(16'h8001, 18);
		chk(data, 16'h8001);
		take;
		chk({15'h0, valid}, 16'h0);
		chk(n_ab[15:0], 16'h1);
	endtask
	task t_full;
		i_host.send(16'h1111, 16);
		i_host.send(16'h2222, 16);
		i_host.send(16'h3333, 16);
		chk(n_ov[15:0], 16'h1);
		chk(data, 16'h1111);
		take;
		chk(data, 16'h2222);
		take;
		chk({15'h0, valid}, 16'h0);
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (abrt === 1'b1)
			n_ab++;
		if (ovr === 1'b1)
			n_ov++;
		if (cyc == 800) begin
			miscompares++;
			test_done;
		end
	end
	initial begin
		rst_n = 1'b0;
		rdy = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_word;
		t_abort;
		t_extra;
		t_full;
		test_done;
	end
endmodule // qdw_serial_port_tb
